// >>> inc/isp_pkg.sv
// Operation
// - read frame returns selected register content
// - pointer advances after every read byte except at the FIFO register
// - FIFO register pointer never advances
// - fast-mode protocol, at most 5 MBaud
// - master drives clock; device never stretches
// - keeper holds data during clock high
// - slave address upper five bits fixed (01010 from config or pin; the default 0101100 has 01011)
// - low bits from config or pin
// - data driven only while clock low
// - each side owns its data enable
// - strictly one master, one slave
// - address from config, default 0101100; in pin mode the lowest bit comes from the pin and the bit above it is 0
// - SPI mode hands link to SPI
// - slave only, no general call
// - MSB first, receiver acknowledges low
// - write: register byte then data bytes
`default_nettype none
package isp_pkg;
  localparam int         BYTE_MSB         = 7;
  localparam int         DIR_POS          = 0;
  localparam int         ADDR_LOW_W       = 2;
  localparam logic [3:0] CNT_ZERO         = 4'h0;
  localparam logic [3:0] CNT_ONE          = 4'h1;
  localparam logic [3:0] CNT_LAST         = 4'h7;
  localparam logic [3:0] CNT_ACK          = 4'h8;
  localparam logic [4:0] ADDR_UPPER       = 5'h0A;
  localparam logic [6:0] NV_ADDR_DEFAULT  = 7'h2C;

  typedef logic [7:0] isp_ptr_t;
  localparam isp_ptr_t   PTR_STEP         = 8'h01;
  localparam isp_ptr_t   FIFO_REG_DEFAULT = 8'h05;

  typedef enum logic [1:0] {
    ISP_REQ_SETPTR,
    ISP_REQ_WRITE,
    ISP_REQ_READ
  } isp_req_e;

  typedef enum logic [2:0] {
    ISP_PH_IDLE,
    ISP_PH_ADDR,
    ISP_PH_REG,
    ISP_PH_WR,
    ISP_PH_RD,
    ISP_PH_SKIP
  } isp_phase_e;

  typedef struct packed {
    isp_req_e   kind;
    logic [7:0] data;
  } isp_req_s;

  typedef struct packed {
    isp_ptr_t   addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } isp_core_s;

  typedef struct packed {
    logic       reqMeta;
    logic       reqSync;
    logic       reqPrev;
    logic       pinMeta;
    logic       pinSync;
    logic [6:0] devAddr;
    isp_ptr_t   ptr;
    logic       rdPend;
    logic [7:0] rdData;
    isp_core_s  core;
  } isp_sys_s;

  typedef struct packed {
    logic       seen;
    isp_phase_e phase;
    logic [3:0] cnt;
    logic [6:0] shift;
    logic       ackOwn;
    logic       reqTog;
    isp_req_s   req;
    logic       keep;
    logic [6:0] addrMeta;
    logic [6:0] addrSync;
    logic       spiMeta;
    logic       spiSync;
  } isp_rise_s;

  typedef struct packed {
    logic       drv;
    logic       dout;
    logic [7:0] tx;
  } isp_fall_s;

  localparam isp_sys_s  SYS_RST  = '0;
  localparam isp_rise_s RISE_RST = '0;
  localparam isp_fall_s FALL_RST = '{drv: 1'h0, dout: 1'h1, tx: 8'h00};
endpackage
`default_nettype wire

// >>> rtl/isp_sam_link.sv
`default_nettype none
module isp_sam_link
  import isp_pkg::*;
#(
  parameter isp_ptr_t FIFO_REG = FIFO_REG_DEFAULT
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       samClockPin,
  input  wire logic       samDataPinIn,
  output var  logic       samDataPinOut,
  output var  logic       samDataPinOe,
  output var  logic       samDataKeep,
  input  wire logic [6:0] nvAddr,
  input  wire logic       nvAddrValid,
  input  wire logic       addrPinMode,
  input  wire logic       addrPin,
  input  wire logic       samSpiMode,
  input  wire logic [7:0] coreRdata,
  output var  isp_core_s  core
);

  isp_sys_s   sr;
  isp_sys_s   sn;
  isp_rise_s  rr;
  isp_rise_s  rn;
  isp_fall_s  fr;
  isp_fall_s  fn;
  logic       startTog;
  logic       startNew;
  logic       reqEdge;
  logic [7:0] byteIn;

  function automatic isp_ptr_t nextPtr(input isp_ptr_t p);
    if (p == FIFO_REG) begin
      nextPtr = p;
    end else begin
      nextPtr = isp_ptr_t'(p + PTR_STEP);
    end
  endfunction

  // start or repeated start: data falls while clock is high;
  // the master holds data high while idle, so this edge is clean
  always_ff @(negedge samDataPinIn or negedge reset_n) begin
    if (!reset_n) begin
      startTog <= 1'h0;
    end else if (samClockPin) begin
      startTog <= ~startTog;
    end
  end

  assign startNew = startTog != rr.seen;
  assign reqEdge  = sr.reqSync != sr.reqPrev;
  assign byteIn   = {rr.shift, samDataPinIn};

  // system side: pointer, core accesses, address selection
  always_comb begin
    sn = sr;
    sn.reqMeta = rr.reqTog;
    sn.reqSync = sr.reqMeta;
    sn.reqPrev = sr.reqSync;
    sn.pinMeta = addrPin;
    sn.pinSync = sr.pinMeta;

    if (addrPinMode) begin
      sn.devAddr = {ADDR_UPPER, 1'h0, sr.pinSync};
    end else if (nvAddrValid) begin
      sn.devAddr = {ADDR_UPPER, nvAddr[ADDR_LOW_W-1:0]};
    end else begin
      sn.devAddr = NV_ADDR_DEFAULT;
    end

    sn.core.rd = 1'h0;
    sn.core.wr = 1'h0;
    sn.rdPend  = 1'h0;
    if (sr.rdPend) begin
      sn.rdData = coreRdata;
    end

    // request words are held by the link for a whole byte time
    if (reqEdge) begin
      case (rr.req.kind)
        ISP_REQ_SETPTR: begin
          sn.ptr = rr.req.data;
        end
        ISP_REQ_WRITE: begin
          sn.core.addr  = sr.ptr;
          sn.core.wdata = rr.req.data;
          sn.core.wr    = 1'h1;
          sn.ptr        = nextPtr(sr.ptr);
        end
        ISP_REQ_READ: begin
          sn.core.addr = sr.ptr;
          sn.core.rd   = 1'h1;
          sn.rdPend    = 1'h1;
          sn.ptr       = nextPtr(sr.ptr);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sr <= SYS_RST;
    end else begin
      sr <= sn;
    end
  end

  // link side, sampling edge: fast-mode byte framing on the master clock
  always_comb begin
    rn = rr;
    rn.addrMeta = sr.devAddr;
    rn.addrSync = rr.addrMeta;
    rn.spiMeta  = samSpiMode;
    rn.spiSync  = rr.spiMeta;
    rn.keep     = samDataPinIn;

    if (startNew) begin
      rn.seen   = startTog;
      rn.cnt    = CNT_ONE;
      rn.shift  = byteIn[BYTE_MSB-1:0];
      rn.ackOwn = 1'h0;
      if (rr.spiSync) begin
        rn.phase = ISP_PH_SKIP;
      end else begin
        rn.phase = ISP_PH_ADDR;
      end
    end else if (rr.cnt == CNT_ACK) begin
      // acknowledge bit is being sampled
      rn.cnt    = CNT_ZERO;
      rn.ackOwn = 1'h0;
      if (rr.phase == ISP_PH_RD) begin
        if (rr.ackOwn || !samDataPinIn) begin
          rn.reqTog   = ~rr.reqTog;
          rn.req.kind = ISP_REQ_READ;
        end else begin
          rn.phase = ISP_PH_SKIP;
        end
      end
    end else if (rr.phase != ISP_PH_IDLE && rr.phase != ISP_PH_SKIP) begin
      rn.cnt   = rr.cnt + CNT_ONE;
      rn.shift = byteIn[BYTE_MSB-1:0];
      if (rr.cnt == CNT_LAST) begin
        case (rr.phase)
          ISP_PH_ADDR: begin
            // general call and other addresses are simply not answered
            if (byteIn[BYTE_MSB:DIR_POS+1] == rr.addrSync) begin
              rn.ackOwn = 1'h1;
              if (byteIn[DIR_POS]) begin
                rn.phase = ISP_PH_RD;
              end else begin
                rn.phase = ISP_PH_REG;
              end
            end else begin
              rn.phase = ISP_PH_SKIP;
            end
          end
          ISP_PH_REG: begin
            rn.ackOwn   = 1'h1;
            rn.reqTog   = ~rr.reqTog;
            rn.req.kind = ISP_REQ_SETPTR;
            rn.req.data = byteIn;
            rn.phase    = ISP_PH_WR;
          end
          ISP_PH_WR: begin
            rn.ackOwn   = 1'h1;
            rn.reqTog   = ~rr.reqTog;
            rn.req.kind = ISP_REQ_WRITE;
            rn.req.data = byteIn;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // the master owns the clock; nothing here can hold it low
  always_ff @(posedge samClockPin or negedge reset_n) begin
    if (!reset_n) begin
      rr <= RISE_RST;
    end else begin
      rr <= rn;
    end
  end

  // link side, driving edge: data changes only after the clock falls
  always_comb begin
    fn     = fr;
    fn.drv = 1'h0;
    if (startNew || rr.spiSync) begin
      fn.drv = 1'h0;
    end else if (rr.cnt == CNT_ACK) begin
      if (rr.ackOwn) begin
        fn.drv  = 1'h1;
        fn.dout = 1'h0;
      end
    end else if (rr.phase == ISP_PH_RD) begin
      fn.drv = 1'h1;
      if (rr.cnt == CNT_ZERO) begin
        // read word is stable: fetched shortly after the previous acknowledge
        fn.tx   = sr.rdData;
        fn.dout = sr.rdData[BYTE_MSB];
      end else begin
        fn.tx   = {fr.tx[BYTE_MSB-1:0], 1'h0};
        fn.dout = fr.tx[BYTE_MSB-1];
      end
    end
  end

  always_ff @(negedge samClockPin or negedge reset_n) begin
    if (!reset_n) begin
      fr <= FALL_RST;
    end else begin
      fr <= fn;
    end
  end

  assign core          = sr.core;
  assign samDataPinOut = fr.dout;
  assign samDataKeep   = rr.keep;
  // enable is cut while the clock is high; the keeper holds the level
  assign samDataPinOe  = fr.drv & ~samClockPin & ~rr.spiSync;

  sequence sReadReq;
    reqEdge && rr.req.kind == ISP_REQ_READ;
  endsequence

  sequence sWriteReq;
    reqEdge && rr.req.kind == ISP_REQ_WRITE;
  endsequence

  sequence sSetReq;
    reqEdge && rr.req.kind == ISP_REQ_SETPTR;
  endsequence

  AST_READ_DATA: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sReadReq |=> sr.core.rd ##1 (sr.rdData == $past(coreRdata)))
    else $error("read data not captured after strobe");

  AST_RD_PULSE: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sr.core.rd |=> !sr.core.rd && !sr.core.wr)
    else $error("read strobe longer than one cycle");

  AST_PTR_STEP: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sReadReq ##0 (sr.ptr != FIFO_REG)
    |=> sr.ptr == isp_ptr_t'($past(sr.ptr) + PTR_STEP) && sr.core.addr == $past(sr.ptr))
    else $error("pointer did not advance after read");

  AST_FIFO_HOLD: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (sReadReq or sWriteReq) ##0 (sr.ptr == FIFO_REG)
    |=> sr.ptr == FIFO_REG && sr.core.addr == FIFO_REG)
    else $error("fifo pointer moved");

  AST_SET_PTR: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sSetReq |=> sr.ptr == $past(rr.req.data) && !sr.core.wr && !sr.core.rd)
    else $error("pointer not loaded by address write");

  AST_WRITE_AT_PTR: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    sWriteReq |=> sr.core.wr && sr.core.wdata == $past(rr.req.data)
    && sr.core.addr == $past(sr.ptr) ##1 !sr.core.wr)
    else $error("write strobe wrong");

  AST_PIN_ADDR: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    addrPinMode [*4] |-> sr.devAddr == {ADDR_UPPER, 1'h0, $past(addrPin, 3)})
    else $error("pin address wrong");

  AST_NV_DEFAULT: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !addrPinMode && !nvAddrValid |=> sr.devAddr == NV_ADDR_DEFAULT)
    else $error("default address not used");

  AST_HIGH_RELEASED: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    samClockPin |-> !samDataPinOe)
    else $error("data driven while clock high");

  AST_ACK_LOW: assert property (
    @(posedge samClockPin) disable iff (!reset_n)
    rr.cnt == CNT_ACK && rr.ackOwn && !rr.spiSync && !startNew
    |-> fr.drv && !fr.dout)
    else $error("acknowledge not driven low");

  AST_NACK_RELEASE: assert property (
    @(posedge samClockPin) disable iff (!reset_n)
    rr.phase == ISP_PH_RD && rr.cnt == CNT_ACK && !rr.ackOwn
    && samDataPinIn && !startNew
    |=> rr.phase == ISP_PH_SKIP && !fr.drv)
    else $error("data not released after nack");

  AST_READ_REQ: assert property (
    @(posedge samClockPin) disable iff (!reset_n)
    rr.phase == ISP_PH_RD && rr.cnt == CNT_ACK && !samDataPinIn && !startNew
    |=> rr.reqTog != $past(rr.reqTog) && rr.req.kind == ISP_REQ_READ
    && rr.cnt == CNT_ZERO)
    else $error("next read not requested");

  AST_SPI_SKIP: assert property (
    @(posedge samClockPin) disable iff (!reset_n)
    rr.spiSync && startNew |=> rr.phase == ISP_PH_SKIP && !rr.ackOwn)
    else $error("link answered in spi mode");

endmodule  // isp_sam_link
`default_nettype wire

// >>> sim/isp_master_model.sv
`default_nettype none
module isp_master_model (
  output var  logic samClockPin,
  output var  logic samDataPinIn,
  input  wire logic samDataPinOut,
  input  wire logic samDataPinOe,
  input  wire logic samDataKeep
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 101.3;
  logic mOe;
  logic mOut;
  logic oeSeen;
  logic keepVal = 1'b1;
  int   errCount = 0;
  initial begin
    samClockPin = 1'b1;
    mOut = 1'b1;
    mOe = 1'b1;
    oeSeen = 1'b0;
  end
  // wire level: master, else device, else the keeper's last level
  always @* begin
    if (mOe) keepVal = mOut;
    else if (samDataPinOe) keepVal = samDataPinOut;
    samDataPinIn = keepVal;
  end
  always @(mOe or samDataPinOe) if (mOe && samDataPinOe) errCount++;
  always @(posedge samDataPinOe) oeSeen = 1'b1;
  task automatic clkBit(input logic drv, input logic val, output logic seen);
    #10 mOut = val;
    mOe = drv;
    #(HALF - 20.0) mOe = 1'b0;
    #10 samClockPin = 1'b1;
    #(HALF / 2.0) seen = samDataPinIn;
    if (samDataPinOe || samDataKeep !== seen) errCount++;
    #(HALF / 2.0) samClockPin = 1'b0;
  endtask
  task automatic frameStart();
    if (!samClockPin) begin
      #10 mOut = 1'b1;
      mOe = 1'b1;
      #(HALF - 10.0) samClockPin = 1'b1;
    end
    #(HALF) mOut = 1'b0;
    #(HALF) samClockPin = 1'b0;
  endtask
  task automatic frameStop();
    #10 mOut = 1'b0;
    mOe = 1'b1;
    #(HALF - 10.0) samClockPin = 1'b1;
    #(HALF) mOut = 1'b1;
    #(2.0 * HALF);
  endtask
  // ack is high when the device pulled the line low in the ninth bit
  task automatic putByte(input logic [7:0] b, output logic ack);
    logic s;
    oeSeen = 1'b0;
    for (int i = 7; i >= 0; i--) clkBit(1'b1, b[i], s);
    clkBit(1'b0, 1'b1, s);
    ack = oeSeen & ~s;
  endtask
  task automatic getByte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clkBit(1'b0, 1'b0, s);
      b[i] = s;
    end
    clkBit(1'b1, nack, s);
  endtask
endmodule // isp_master_model
`default_nettype wire

// >>> sim/isp_sam_link_tb_top.sv
`default_nettype none
module isp_sam_link_tb_top
  import isp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam isp_ptr_t FIFO_R = 8'h21;
  logic        clk_sys;
  logic        reset_n;
  logic        samClockPin;
  logic        samDataPinIn;
  logic        samDataPinOut;
  logic        samDataPinOe;
  logic        samDataKeep;
  logic [6:0]  nvAddr;
  logic        nvAddrValid;
  logic        addrPinMode;
  logic        addrPin;
  logic        samSpiMode;
  logic [7:0]  coreRdata;
  isp_core_s   core;
  logic [7:0]  fifoCnt;
  logic [15:0] wrQ[$];
  int          bad_count;
  int          comparisons;
  isp_sam_link #(.FIFO_REG(FIFO_R)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .samClockPin(samClockPin),
    .samDataPinIn(samDataPinIn), .samDataPinOut(samDataPinOut),
    .samDataPinOe(samDataPinOe), .samDataKeep(samDataKeep), .nvAddr(nvAddr),
    .nvAddrValid(nvAddrValid), .addrPinMode(addrPinMode), .addrPin(addrPin),
    .samSpiMode(samSpiMode), .coreRdata(coreRdata), .core(core));
  isp_master_model mst_u (
    .samClockPin(samClockPin), .samDataPinIn(samDataPinIn),
    .samDataPinOut(samDataPinOut), .samDataPinOe(samDataPinOe),
    .samDataKeep(samDataKeep));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] regVal(input isp_ptr_t a);
    return a ^ 8'h5A;
  endfunction
  // register file stand-in; the fifo hands out a running count
  // read word stands while the strobe is high; the link takes it at the next edge
  always_comb coreRdata = (core.addr === FIFO_R) ? fifoCnt : regVal(core.addr);
  always @(posedge clk_sys) begin
    if (core.rd === 1'b1 && core.addr === FIFO_R) fifoCnt <= fifoCnt + 8'h01;
    if (core.wr === 1'b1) wrQ.push_back({core.addr, core.wdata});
  end
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setCfg(input logic v, input logic pm, input logic pin, input logic spi,
                        input logic [6:0] nv);
    @(posedge clk_sys);
    #1 nvAddrValid = v;
    addrPinMode = pm;
    addrPin = pin;
    samSpiMode = spi;
    nvAddr = nv;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic probe(input logic [6:0] a, output logic ack);
    mst_u.frameStart();
    mst_u.putByte({a, 1'b0}, ack);
    mst_u.frameStop();
  endtask
  task automatic writeRun(input logic [6:0] own, input isp_ptr_t p, input int n);
    logic       ack;
    logic [7:0] d[4];
    wrQ.delete();
    mst_u.frameStart();
    mst_u.putByte({own, 1'b0}, ack);
    mst_u.putByte(p, ack);
    for (int i = 0; i < n; i++) begin
      d[i] = 8'($urandom);
      mst_u.putByte(d[i], ack);
    end
    mst_u.frameStop();
    chk("write count", 8'(n), 8'(wrQ.size()));
    for (int i = 0; i < n; i++) begin
      chk("write addr", (p == FIFO_R) ? p : p + 8'(i), wrQ[i][15:8]);
      chk("write data", d[i], wrQ[i][7:0]);
    end
  endtask
  task automatic readRun(input logic [6:0] own, input isp_ptr_t p, input int n);
    logic       ack;
    logic [7:0] b;
    logic [7:0] base;
    wrQ.delete();
    mst_u.frameStart();
    mst_u.putByte({own, 1'b0}, ack);
    mst_u.putByte(p, ack);
    mst_u.frameStart();
    chk("pointer write count", 8'h00, 8'(wrQ.size()));
    // the first fetch follows the address acknowledge, so take the base first
    base = fifoCnt;
    mst_u.putByte({own, 1'b1}, ack);
    chk("read ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++) begin
      mst_u.getByte(i == n - 1, b);
      chk("read data", (p == FIFO_R) ? base + 8'(i) : regVal(p + 8'(i)), b);
    end
    mst_u.frameStop();
  endtask
  initial begin
    logic        ack;
    logic [6:0]  own;
    logic [6:0]  pa;
    logic [31:0] rnd;
    bad_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    nvAddr = 7'h00;
    nvAddrValid = 1'b0;
    addrPinMode = 1'b0;
    addrPin = 1'b0;
    samSpiMode = 1'b0;
    fifoCnt = 8'h80;
    rnd = $urandom(32'hAD802FD7);
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    // default address, config bits, then the pin with the upper low bit forced low
    for (int m = 0; m < 4; m++) begin
      rnd = $urandom;
      setCfg(m > 0, m > 1, m[0], 1'b0, rnd[6:0]);
      own = (m > 1) ? {5'h0A, 1'b0, m[0]} : (m > 0) ? {5'h0A, rnd[1:0]} : 7'h2C;
      // four neighbours of the fixed upper part, then the expected own address
      for (int p = 0; p < 5; p++) begin
        pa = (p == 4) ? own : {5'h0A, p[1:0]};
        probe(pa, ack);
        chk("address ack", {7'h00, pa == own}, {7'h00, ack});
      end
    end
    probe(7'h00, ack);
    chk("general call ack", 8'h00, {7'h00, ack});
    writeRun(own, 8'h80 | 8'($urandom % 64), 3);
    writeRun(own, FIFO_R, 2);
    for (int r = 0; r < 3; r++) begin
      readRun(own, (r == 1) ? FIFO_R : 8'h80 | 8'($urandom % 60), 2 + $urandom % 3);
    end
    // mode select reaches the link through link clock rises: one dummy frame each way
    setCfg(1'b1, 1'b1, 1'b1, 1'b1, 7'h00);
    probe(7'h00, ack);
    probe(own, ack);
    chk("spi mode ack", 8'h00, {7'h00, ack});
    setCfg(1'b1, 1'b1, 1'b1, 1'b0, 7'h00);
    probe(7'h00, ack);
    readRun(own, 8'h90, 2);
    chk("link drive faults", 8'h00, {7'h00, mst_u.errCount != 0});
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    $display("ERROR run length expected done seen timeout");
    final_report();
  end
endmodule // isp_sam_link_tb_top
`default_nettype wire
